// ### design/hub_deadline_timer.sv
// cycle counter that raises a registered expiry flag after limit cycles of run
// assumes run is held for the whole interval; dropping run clears the count
`timescale 1ns/1ns
module hub_deadline_timer #(
  parameter int W = 25
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  logic [W-1:0] count_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (!run) begin
      count_q <= '0;
    end else if (count_q != limit) begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      expired <= 1'b0;
    end else begin
      expired <= run && (count_q + 1'b1 >= limit);
    end
  end

endmodule

// ### design/hub_reset_config_sequencer.sv
// start-up sequencer: mode select, strap capture, config load, attach, bus reset
// assumes all inputs synchronous to core_clk; reset_n validity is the board's job
`timescale 1ns/1ns
`include "hub_seq_defines.svh"
module hub_reset_config_sequencer #(
  parameter int PORTS       = 2,
  parameter int STRAP_W     = 2,
  parameter int TEST_W      = 16,
  parameter int RECOVER_CYC = `HUB_T_RECOVER_US * `HUB_CLK_MHZ,
  parameter int CFG_CYC     = `HUB_T_CFG_LOAD_US * `HUB_CLK_MHZ,
  parameter int REQ_CYC     = `HUB_T_REQ_MS * 1000 * `HUB_CLK_MHZ
) (
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic [1:0]         cfg_sel,
  input  wire logic               test_pin,
  input  wire logic               sclk_in,
  input  wire logic               self_powered,
  input  wire logic [STRAP_W-1:0] led_in,
  output logic      [STRAP_W-1:0] led_out,
  output logic      [STRAP_W-1:0] led_oe,
  input  wire logic [STRAP_W-1:0] led_on,
  output logic                    eeprom_start,
  output logic                    smbus_slave_en,
  input  wire logic               cfg_load_done,
  input  wire logic [7:0]         cfg_load_data,
  output logic      [7:0]         cfg_word,
  output logic                    cfg_fallback,
  output logic                    upstream_attach,
  input  wire logic               usb_bus_reset,
  input  wire logic               set_addr_stb,
  input  wire logic [6:0]         set_addr_val,
  output logic      [6:0]         dev_addr,
  input  wire logic               set_config_stb,
  input  wire logic               set_config_val,
  output logic                    configured,
  input  wire logic               suspend_enter,
  input  wire logic               resume_req,
  output logic                    suspended,
  input  wire logic               port_power_stb,
  input  wire logic [PORTS-1:0]   port_power_val,
  output logic      [PORTS-1:0]   port_power_enable,
  input  wire logic [PORTS-1:0]   port_reset_req,
  output logic      [PORTS-1:0]   downstream_port_reset,
  output logic                    tt_flush,
  input  wire logic               ctrl_req_start,
  input  wire logic               ctrl_req_done,
  output logic                    ctrl_req_abort,
  input  wire logic [TEST_W-1:0]  continuity_pins,
  output logic                    continuity_result_out
);

  localparam int INACTIVE_CYC = (`HUB_T_INACTIVE_NS * `HUB_CLK_MHZ) / 1000;
  localparam int TW = 25;
  localparam logic [7:0] CFG_DEF = `HUB_CFG_DEFAULT;

  hub_seq_pkg::seq_state_e state_q;
  hub_seq_pkg::cfg_mode_e  mode_d;
  logic                    test_d;
  logic [STRAP_W-1:0]      strap_q;
  logic                    rec_exp;
  logic                    cfg_exp;
  logic                    req_exp;
  logic                    req_busy_q;
  logic                    running;

  assign running = (state_q == hub_seq_pkg::ST_RUN);

  // decode of the levels seen in the first cycle after release
  always_comb begin
    test_d = test_pin && cfg_sel[1] && !sclk_in;
    case (cfg_sel)
      `HUB_SEL_EEPROM: mode_d = hub_seq_pkg::MODE_EEPROM;
      `HUB_SEL_SMBUS:  mode_d = hub_seq_pkg::MODE_SMBUS;
      default:         mode_d = hub_seq_pkg::MODE_STRAP;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= hub_seq_pkg::ST_SAMPLE;
    end else begin
      case (state_q)
        hub_seq_pkg::ST_SAMPLE: begin
          if (test_d) begin
            state_q <= hub_seq_pkg::ST_TEST;
          end else if (mode_d == hub_seq_pkg::MODE_STRAP) begin
            state_q <= hub_seq_pkg::ST_ATTACH;
          end else begin
            state_q <= hub_seq_pkg::ST_RECOVER;
          end
        end
        hub_seq_pkg::ST_RECOVER: begin
          if (rec_exp) begin
            state_q <= smbus_slave_en ? hub_seq_pkg::ST_SMBUS : hub_seq_pkg::ST_EEPROM;
          end
        end
        hub_seq_pkg::ST_EEPROM: begin
          if (cfg_load_done || cfg_exp) begin
            state_q <= hub_seq_pkg::ST_ATTACH;
          end
        end
        hub_seq_pkg::ST_SMBUS: begin
          if (cfg_load_done || (cfg_exp && !self_powered)) begin
            state_q <= hub_seq_pkg::ST_ATTACH;
          end
        end
        hub_seq_pkg::ST_ATTACH: state_q <= hub_seq_pkg::ST_RUN;
        hub_seq_pkg::ST_RUN:    state_q <= hub_seq_pkg::ST_RUN;
        hub_seq_pkg::ST_TEST:   state_q <= hub_seq_pkg::ST_TEST;
        default:                state_q <= hub_seq_pkg::ST_SAMPLE;
      endcase
    end
  end

  // smbus_slave_en doubles as the remembered mode choice between sample and load
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      smbus_slave_en <= 1'b0;
    end else if (state_q == hub_seq_pkg::ST_SAMPLE) begin
      smbus_slave_en <= !test_d && (mode_d == hub_seq_pkg::MODE_SMBUS);
    end else if (state_q == hub_seq_pkg::ST_ATTACH) begin
      smbus_slave_en <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_start <= 1'b0;
    end else begin
      eeprom_start <= (state_q == hub_seq_pkg::ST_RECOVER) && rec_exp && !smbus_slave_en;
    end
  end

  hub_deadline_timer #(.W(TW)) u_recover_timer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .run      (state_q == hub_seq_pkg::ST_RECOVER),
    .limit    (TW'(RECOVER_CYC)),
    .expired  (rec_exp)
  );

  hub_deadline_timer #(.W(TW)) u_cfg_timer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .run      (state_q == hub_seq_pkg::ST_EEPROM || state_q == hub_seq_pkg::ST_SMBUS),
    .limit    (TW'(CFG_CYC)),
    .expired  (cfg_exp)
  );

  hub_deadline_timer #(.W(TW)) u_req_timer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .run      (req_busy_q),
    .limit    (TW'(REQ_CYC)),
    .expired  (req_exp)
  );

  // configuration word: straps over defaults, loaded data, or defaults on a missed load
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_q      <= '0;
      cfg_word     <= `HUB_CFG_DEFAULT;
      cfg_fallback <= 1'b0;
    end else if (state_q == hub_seq_pkg::ST_SAMPLE) begin
      strap_q  <= led_in;
      cfg_word <= {CFG_DEF[7:STRAP_W], led_in};
    end else if ((state_q == hub_seq_pkg::ST_EEPROM || state_q == hub_seq_pkg::ST_SMBUS)
                 && cfg_load_done) begin
      cfg_word <= cfg_load_data;
    end else if ((state_q == hub_seq_pkg::ST_EEPROM || state_q == hub_seq_pkg::ST_SMBUS)
                 && cfg_exp && !(smbus_slave_en && self_powered)) begin
      cfg_word     <= `HUB_CFG_DEFAULT;
      cfg_fallback <= 1'b1;
    end
  end

  // a strap high means an active-low LED, so the strap level is the idle level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      led_oe  <= '0;
      led_out <= '0;
    end else if (state_q != hub_seq_pkg::ST_SAMPLE && state_q != hub_seq_pkg::ST_TEST) begin
      led_oe  <= '1;
      led_out <= strap_q ^ (led_on & {STRAP_W{running}});
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      upstream_attach <= 1'b0;
    end else if (state_q == hub_seq_pkg::ST_ATTACH) begin
      upstream_attach <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_addr   <= `HUB_ADDR_RESET;
      configured <= 1'b0;
    end else if (usb_bus_reset) begin
      dev_addr   <= `HUB_ADDR_RESET;
      configured <= 1'b0;
    end else if (running) begin
      if (set_addr_stb) begin
        dev_addr <= set_addr_val;
      end
      if (set_config_stb) begin
        configured <= set_config_val;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_power_enable <= '0;
    end else if (usb_bus_reset || !running) begin
      port_power_enable <= '0;
    end else if (port_power_stb) begin
      port_power_enable <= port_power_val;
    end
  end

  // bus reset wins over a suspend request in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      suspended <= 1'b0;
    end else if (usb_bus_reset || resume_req || !running) begin
      suspended <= 1'b0;
    end else if (suspend_enter) begin
      suspended <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tt_flush              <= 1'b0;
      downstream_port_reset <= '0;
    end else begin
      tt_flush              <= usb_bus_reset;
      downstream_port_reset <= port_reset_req & {PORTS{running && !usb_bus_reset}};
    end
  end

  // a request still open at the deadline is ended with an abort pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_busy_q     <= 1'b0;
      ctrl_req_abort <= 1'b0;
    end else begin
      ctrl_req_abort <= req_busy_q && req_exp && !ctrl_req_done;
      if (ctrl_req_done || req_exp || usb_bus_reset || !running) begin
        req_busy_q <= 1'b0;
      end else if (ctrl_req_start) begin
        req_busy_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      continuity_result_out <= 1'b0;
    end else if (state_q == hub_seq_pkg::ST_TEST) begin
      continuity_result_out <= ~^continuity_pins;
    end
  end

  sequence s_release;
    state_q == hub_seq_pkg::ST_SAMPLE && !test_d;
  endsequence

  sequence s_bus_reset;
    running && usb_bus_reset;
  endsequence

  a_led_inactive: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_release |-> ##[1:INACTIVE_CYC] (led_oe == '1 && led_out == strap_q))
    else $error("led outputs not idle in time");
  a_strap_capture: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == hub_seq_pkg::ST_SAMPLE |=> strap_q == $past(led_in))
    else $error("strap levels not captured");
  a_default_fill: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_release ##0 mode_d == hub_seq_pkg::MODE_STRAP
      |=> cfg_word == {CFG_DEF[7:STRAP_W], strap_q})
    else $error("strap config word wrong");
  a_eeprom_deadline: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == hub_seq_pkg::ST_EEPROM && cfg_exp |=> state_q == hub_seq_pkg::ST_ATTACH)
    else $error("eeprom load overran");
  a_smbus_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == hub_seq_pkg::ST_SMBUS && self_powered && !cfg_load_done
      |=> state_q == hub_seq_pkg::ST_SMBUS)
    else $error("self powered smbus wait cut short");
  a_attach_after_cfg: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(state_q == hub_seq_pkg::ST_ATTACH) |-> ##[1:2] upstream_attach)
    else $error("attach late");
  a_req_deadline: assert property (@(posedge core_clk) disable iff (!reset_n)
    req_busy_q && req_exp && !ctrl_req_done |=> ctrl_req_abort ##1 !ctrl_req_abort)
    else $error("request not ended at deadline");
  a_busrst_state: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_bus_reset |=> dev_addr == `HUB_ADDR_RESET && !configured)
    else $error("address or config kept over bus reset");
  a_busrst_power: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_bus_reset |=> port_power_enable == '0)
    else $error("port power kept over bus reset");
  a_busrst_flush: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_bus_reset |=> tt_flush)
    else $error("no buffer flush on bus reset");
  a_busrst_wake: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_bus_reset ##0 suspended |=> !suspended)
    else $error("still suspended after bus reset");
  a_no_forward: assert property (@(posedge core_clk) disable iff (!reset_n)
    usb_bus_reset |=> downstream_port_reset == '0)
    else $error("bus reset forwarded downstream");
  a_xnor_chain: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == hub_seq_pkg::ST_TEST ##1 $onehot(continuity_pins ^ $past(continuity_pins))
      |=> $changed(continuity_result_out))
    else $error("continuity output did not toggle");
  a_mode_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == hub_seq_pkg::ST_RECOVER && rec_exp && smbus_slave_en
      |=> state_q == hub_seq_pkg::ST_SMBUS && !eeprom_start)
    else $error("eeprom read in smbus mode");
  a_eeprom_only: assert property (@(posedge core_clk) disable iff (!reset_n)
    eeprom_start |-> state_q == hub_seq_pkg::ST_EEPROM && !smbus_slave_en)
    else $error("eeprom read outside eeprom mode");

endmodule

// ### shared/hub_seq_defines.svh
// timing figures, strap/select encodings and reset values of the start-up sequencer
// assumes a single core clock whose rate is given in MHz below
`ifndef HUB_SEQ_DEFINES_SVH
`define HUB_SEQ_DEFINES_SVH

`define HUB_CLK_MHZ         250
`define HUB_T_INACTIVE_NS   1500
`define HUB_T_RECOVER_US    500
`define HUB_T_CFG_LOAD_US   99500
`define HUB_T_REQ_MS        5

`define HUB_SEL_EEPROM      2'h1
`define HUB_SEL_SMBUS       2'h2

`define HUB_CFG_DEFAULT     8'h00
`define HUB_ADDR_RESET      7'h00

`endif

// ### shared/hub_seq_pkg.sv
// types used by the start-up sequencer; its timer uses none of them
// assumes the defines header is compiled alongside
package hub_seq_pkg;

  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_RECOVER,
    ST_EEPROM,
    ST_SMBUS,
    ST_ATTACH,
    ST_RUN,
    ST_TEST
  } seq_state_e;

  typedef enum logic [1:0] {
    MODE_STRAP,
    MODE_EEPROM,
    MODE_SMBUS
  } cfg_mode_e;

endpackage

// ### verif/hub_far_side.sv
// far-side model: configuration loader (eeprom or smbus host) and upstream host
// assumes one core clock; commands from the bench are changed at rising edges
`timescale 1ns/1ns
module hub_far_side #(
  parameter int HOST_WAIT = 10,
  parameter int RST_LEN   = 3
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        eeprom_start,
  input  wire logic        smbus_slave_en,
  input  wire logic        upstream_attach,
  input  wire logic        host_reset_req,
  input  wire logic        load_enable,
  input  wire logic [15:0] load_delay,
  input  wire logic [7:0]  load_value,
  output logic             cfg_load_done,
  output logic      [7:0]  cfg_load_data,
  output logic             usb_bus_reset
);
  int   attach_cnt_q;
  logic busy;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) attach_cnt_q <= 0;
    else if (!upstream_attach) attach_cnt_q <= 0;
    else if (attach_cnt_q < HOST_WAIT) attach_cnt_q <= attach_cnt_q + 1;
  end

  // one load per reset; data is only meaningful with the done pulse
  initial begin
    cfg_load_done = 1'b0;
    cfg_load_data = 8'h5a;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (!reset_n) begin
        busy = 1'b0;
      end else if (!busy && load_enable && (eeprom_start || smbus_slave_en)) begin
        busy = 1'b1;
        repeat (load_delay) @(posedge core_clk);
        cfg_load_done <= 1'b1;
        cfg_load_data <= load_value;
        @(posedge core_clk);
        cfg_load_done <= 1'b0;
        cfg_load_data <= ~load_value;
      end
    end
  end

  // host signals a bus reset only after the hub has stayed attached a while
  initial begin
    usb_bus_reset = 1'b0;
    forever begin
      @(posedge core_clk);
      if (host_reset_req && attach_cnt_q >= HOST_WAIT) begin
        usb_bus_reset <= 1'b1;
        repeat (RST_LEN) @(posedge core_clk);
        usb_bus_reset <= 1'b0;
        wait (!host_reset_req);
      end
    end
  end
endmodule

// ### verif/tb_hub_reset_config_sequencer.sv
// testbench of the start-up sequencer with far-side model
// assumes shortened deadline parameters; expectations derive from them
`timescale 1ns/1ns
`include "hub_seq_defines.svh"
module tb_hub_reset_config_sequencer;
  localparam int REC = 20;
  localparam int CFG = 200;
  localparam int REQ = 50;
  typedef struct {int sel; logic [7:0] exp;} note_s;
  logic        core_clk, reset_n, test_pin, sclk_in, self_powered, eeprom_start;
  logic        smbus_slave_en, cfg_load_done, cfg_fallback, upstream_attach, usb_bus_reset;
  logic        set_addr_stb, set_config_stb, set_config_val, configured, suspend_enter;
  logic        resume_req, suspended, port_power_stb, tt_flush, ctrl_req_start;
  logic        ctrl_req_done, ctrl_req_abort, continuity_result_out, host_reset_req;
  logic        load_enable;
  logic [1:0]  cfg_sel, led_in, led_on, led_out, led_oe, strap, port_power_val;
  logic [1:0]  port_power_enable, port_reset_req, downstream_port_reset;
  logic [7:0]  cfg_load_data, cfg_word, load_value;
  logic [6:0]  set_addr_val, dev_addr, a;
  logic [15:0] load_delay, continuity_pins, p;
  int          failures, tests_run;
  note_s       notes[$];
  note_s       nt;
  event        chk_ev;
  string nm[14] = '{"attach", "cfg_word", "fallback", "led_oe", "led_out", "dev_addr",
    "configured", "port_power", "suspended", "port_reset", "continuity", "tt_flush", "abort",
    "smbus_en"};

  hub_reset_config_sequencer #(.RECOVER_CYC(REC), .CFG_CYC(CFG), .REQ_CYC(REQ)) uut (
    .core_clk, .reset_n, .cfg_sel, .test_pin, .sclk_in, .self_powered, .led_in, .led_out,
    .led_oe, .led_on, .eeprom_start, .smbus_slave_en, .cfg_load_done, .cfg_load_data,
    .cfg_word, .cfg_fallback, .upstream_attach, .usb_bus_reset, .set_addr_stb,
    .set_addr_val, .dev_addr, .set_config_stb, .set_config_val, .configured,
    .suspend_enter, .resume_req, .suspended, .port_power_stb, .port_power_val,
    .port_power_enable, .port_reset_req, .downstream_port_reset, .tt_flush,
    .ctrl_req_start, .ctrl_req_done, .ctrl_req_abort, .continuity_pins,
    .continuity_result_out);
  hub_far_side far (
    .core_clk, .reset_n, .eeprom_start, .smbus_slave_en, .upstream_attach, .host_reset_req,
    .load_enable, .load_delay, .load_value, .cfg_load_done, .cfg_load_data, .usb_bus_reset);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [7:0] obs(int s);
    case (s)
      0: return {7'h00, upstream_attach};
      1: return cfg_word;
      2: return {7'h00, cfg_fallback};
      3: return {6'h00, led_oe};
      4: return {6'h00, led_out};
      5: return {1'b0, dev_addr};
      6: return {7'h00, configured};
      7: return {6'h00, port_power_enable};
      8: return {7'h00, suspended};
      9: return {6'h00, downstream_port_reset};
      10: return {7'h00, continuity_result_out};
      11: return {7'h00, tt_flush};
      12: return {7'h00, ctrl_req_abort};
      default: return {7'h00, smbus_slave_en};
    endcase
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic note(int s, logic [7:0] e);
    notes.push_back('{s, e});
    -> chk_ev;
  endtask

  initial forever begin
    @(chk_ev);
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      check(nm[nt.sel], obs(nt.sel), nt.exp);
    end
  end

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_hi(int s, int max);
    int n;
    n = 0;
    while (obs(s) !== 8'h01 && n < max) begin
      tick(1);
      n++;
    end
  endtask

  task automatic boot(logic [1:0] s, logic t, logic c, logic pw);
    @(posedge core_clk);
    reset_n <= 1'b0;
    cfg_sel <= s;
    test_pin <= t;
    sclk_in <= c;
    self_powered <= pw;
    strap = 2'($urandom);
    led_in <= strap;
    // mid-run resets last 1 us (250 cycles at 4 ns)
    repeat (tests_run > 0 ? 250 : 12) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask

  // eeprom or smbus load: nothing attached early, then attach by the deadline, or at the late load when smbus is self-powered
  task automatic cfg_case(logic [1:0] s, logic pw, logic en, int dly, int early);
    logic [7:0] v;
    v = 8'($urandom);
    boot(s, 1'b0, 1'b1, pw);
    load_enable <= en;
    load_delay <= 16'(dly);
    load_value <= v;
    tick(early);
    note(0, 8'h00);
    note(13, {7'h00, s == 2'h2});
    wait_hi(0, REC + CFG + 10);
    note(0, 8'h01);
    note(13, 8'h00);
    note(1, en ? v : `HUB_CFG_DEFAULT);
    note(2, en ? 8'h00 : 8'h01);
    $display("test load mode %b done", s);
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(20000 * 4);
    failures++;
    finish_test();
  end

  initial begin
    reset_n = 1'b0;
    {cfg_sel, test_pin, sclk_in, self_powered, led_in, led_on, set_addr_stb, set_addr_val,
     set_config_stb, set_config_val, suspend_enter, resume_req, port_power_stb,
     port_power_val, port_reset_req, ctrl_req_start, ctrl_req_done, continuity_pins,
     host_reset_req, load_enable, load_delay, load_value} = '0;
    p = 16'($urandom(32'h408f197c));
    for (int i = 0; i < 2; i++) begin
      boot(i ? 2'h3 : 2'h0, 1'b0, 1'b1, 1'b0);
      tick(1);
      wait_hi(0, 4);
      note(0, 8'h01);
      note(1, `HUB_CFG_DEFAULT | {6'h00, strap});
      note(3, 8'h03);
      note(4, {6'h00, strap});
    end
    @(posedge core_clk);
    led_on <= ~strap;
    tick(2);
    note(4, 8'h03);
    $display("test strap done");
    a = 7'($urandom_range(127, 1));
    @(posedge core_clk);
    {set_addr_stb, set_config_stb, set_config_val, port_power_stb, suspend_enter} <= 5'h1f;
    set_addr_val <= a;
    port_power_val <= 2'h3;
    @(posedge core_clk);
    {set_addr_stb, set_config_stb, port_power_stb, suspend_enter} <= 4'h0;
    port_reset_req <= 2'h1;
    tick(1);
    note(5, {1'b0, a});
    note(6, 8'h01);
    note(7, 8'h03);
    note(8, 8'h01);
    note(9, 8'h01);
    @(posedge core_clk);
    port_reset_req <= 2'h0;
    host_reset_req <= 1'b1;
    wait_hi(11, 40);
    note(11, 8'h01);
    note(5, 8'h00);
    note(6, 8'h00);
    note(7, 8'h00);
    note(8, 8'h00);
    note(9, 8'h00);
    tick(4);
    note(11, 8'h00);
    host_reset_req <= 1'b0;
    $display("test bus reset done");
    @(posedge core_clk);
    ctrl_req_start <= 1'b1;
    @(posedge core_clk);
    ctrl_req_start <= 1'b0;
    tick(REQ - 5);
    note(12, 8'h00);
    wait_hi(12, 10);
    note(12, 8'h01);
    tick(1);
    note(12, 8'h00);
    @(posedge core_clk);
    ctrl_req_start <= 1'b1;
    @(posedge core_clk);
    ctrl_req_start <= 1'b0;
    repeat (10) @(posedge core_clk);
    ctrl_req_done <= 1'b1;
    @(posedge core_clk);
    ctrl_req_done <= 1'b0;
    repeat (REQ + 10) begin
      tick(1);
      note(12, 8'h00);
    end
    $display("test request deadline done");
    cfg_case(2'h1, 1'b0, 1'b1, 30, 15);
    cfg_case(2'h1, 1'b0, 1'b0, 1, 15);
    cfg_case(2'h2, 1'b0, 1'b0, 1, 15);
    cfg_case(2'h2, 1'b1, 1'b1, 300, 250);
    boot(2'h2, 1'b1, 1'b0, 1'b0);
    tick(3);
    note(3, 8'h00);
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      p = (i < 4) ? 16'($urandom) : p ^ (16'h0001 << (i * 5 % 16));
      continuity_pins <= p;
      tick(1);
      note(10, {7'h00, ~^p});
    end
    $display("test continuity done");
    finish_test();
  end
endmodule
